// ---- common/csr_pkg.sv ----
/*
 * Shared constants for the clock select and reset cause block.
 * Assumes a 200 MHz system clock and APB with 32-bit data.
 */
package csr_pkg;
    // Register byte offsets
    localparam logic [11:0] CSR_CLK_CONF_OFS = 12'h000;
    localparam logic [11:0] CSR_PRESCALE_OFS = 12'h004;
    localparam logic [11:0] CSR_RST_CTRL_OFS = 12'h008;
    localparam logic [11:0] CSR_CAUSE_OFS = 12'h00C;
    localparam logic [11:0] CSR_STATUS_OFS = 12'h010;
    localparam logic [11:0] CSR_FAST_DIV_OFS = 12'h014;
    // Clock configuration fields
    localparam int CSR_SRC_LSB = 0;
    localparam int CSR_PLL_FREQ_BIT = 2;
    localparam int CSR_PERIOD_BIT = 3;
    localparam int CSR_APB_EN_BIT = 4;
    localparam int CSR_SLOW_LSB = 5;
    localparam int CSR_FAST_SEL_BIT = 7;
    localparam int CSR_RADIO_EN_BIT = 8;
    // Reset control fields
    localparam int CSR_SW_SYS_BIT = 0;
    localparam int CSR_SW_CPU_BIT = 1;
    localparam int CSR_BOD_CHIP_BIT = 2;
    // Reset values
    localparam logic [8:0] CSR_CLK_CONF_RST = 9'h010;
    localparam logic [9:0] CSR_PRESCALE_RST = 10'h001;
    localparam logic [9:0] CSR_FAST_DIV_RST = 10'h001;
    // Core clock source codes
    localparam logic [1:0] CSR_SRC_XTAL = 2'h0;
    localparam logic [1:0] CSR_SRC_PLL = 2'h1;
    localparam logic [1:0] CSR_SRC_FAST_RC = 2'h2;
    // Slow domain source codes
    localparam logic [1:0] CSR_SLOW_RC = 2'h0;
    localparam logic [1:0] CSR_SLOW_LF_XTAL = 2'h1;
    localparam logic [1:0] CSR_SLOW_DIV_RC = 2'h2;
    // Division ratios
    localparam logic [9:0] CSR_PLL480_DIV80 = 10'h006;
    localparam logic [9:0] CSR_PLL480_DIV160 = 10'h003;
    localparam logic [9:0] CSR_PLL320_DIV80 = 10'h004;
    localparam logic [9:0] CSR_PLL320_DIV160 = 10'h002;
    localparam logic [9:0] CSR_FAST_RC_DIV = 10'h100;
    // Reset cause codes
    localparam logic [7:0] CSR_CAUSE_CHIP = 8'h01;
    localparam logic [7:0] CSR_CAUSE_BROWNOUT = 8'h0F;
    localparam logic [7:0] CSR_CAUSE_SW_SYS = 8'h03;
    localparam logic [7:0] CSR_CAUSE_SW_CPU = 8'h0C;
    localparam logic [7:0] CSR_CAUSE_FUSE = 8'h14;
    // Reset pulse length
    localparam int CSR_CLK_MHZ = 200;
    localparam int CSR_RST_HOLD_NS = 100;
    localparam int CSR_RST_HOLD_CYC = (CSR_RST_HOLD_NS * CSR_CLK_MHZ + 999) / 1000;
    // Radio handoff states
    typedef enum logic {
        CSR_ST_RUN,
        CSR_ST_WAIT_SLEEP
    } csr_radio_st_t;
endpackage

// ---- dv/csr_top_monitor.sv ----
/*
 * Port checker for the clock select and reset cause block.
 * Assumes one clock domain and attachment through the bind below.
 */
`timescale 1ns/1ps
module csr_top_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic brownOutEvent,
    input wire logic fuseCrcError,
    input wire logic cpuRst,
    input wire logic digitalRst,
    input wire logic rtcDomainRst,
    input wire logic chipRst,
    input wire logic memoryRst,
    input wire logic radioRun,
    input wire logic radioSleepReq,
    input wire logic pllInUse
);
    import csr_pkg::*;
    // Offsets that answer without error
    wire logic mapped = paddr inside {CSR_CLK_CONF_OFS, CSR_PRESCALE_OFS, CSR_RST_CTRL_OFS,
        CSR_CAUSE_OFS, CSR_STATUS_OFS, CSR_FAST_DIV_OFS};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Access phase of a transfer
    sequence s_access;
        psel && penable;
    endsequence
    // Core level only, always-on domain spared
    sequence s_core_only;
        digitalRst && !rtcDomainRst;
    endsequence
    a_ready_now: assert property (s_access |-> pready) else $error("pready low in access");
    a_idle_quiet: assert property (!penable |-> !pready) else $error("pready outside access");
    a_unmapped_error: assert property (s_access ##0 !mapped |-> pslverr) else $error("no error on hole");
    a_mapped_okay: assert property (s_access ##0 mapped |-> !pslverr) else $error("error on register");
    a_reset_nest: assert property ((!chipRst || rtcDomainRst) && (!rtcDomainRst || digitalRst)
        && (!digitalRst || cpuRst)) else $error("reset levels not nested");
    a_memory_chip: assert property (memoryRst == chipRst) else $error("memory reset not chip level");
    a_brownout_hold: assert property (brownOutEvent |=> rtcDomainRst && cpuRst)
        else $error("brown-out gave no reset");
    a_fuse_core: assert property (fuseCrcError && !brownOutEvent && !rtcDomainRst |=> s_core_only)
        else $error("fuse error not core level");
    a_radio_pll: assert property (radioRun |-> pllInUse) else $error("radio runs off pll");
    a_sleep_holds: assert property (radioSleepReq |-> pllInUse && !radioRun)
        else $error("pll left before radio slept");
    a_release_clean: assert property ($fell(rst) |-> !cpuRst && !memoryRst)
        else $error("reset outputs high after release");
endmodule // csr_top_monitor

bind csr_top csr_top_monitor u_mon (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .brownOutEvent(brownOutEvent), .fuseCrcError(fuseCrcError),
    .cpuRst(cpuRst), .digitalRst(digitalRst), .rtcDomainRst(rtcDomainRst), .chipRst(chipRst),
    .memoryRst(memoryRst), .radioRun(radioRun), .radioSleepReq(radioSleepReq), .pllInUse(pllInUse));

// ---- dv/csr_top_tb.sv ----
/*
 * Self-checking bench for the clock select and reset cause block.
 * Assumes the checker is bound separately; source clocks are tick pulses.
 */
`timescale 1ns/1ps
module csr_top_tb;
    import csr_pkg::*;
    localparam int HOLD = 4; // Short hold keeps runs brief
    localparam int LIMIT = 20000;
    // Clock table rows: config, prescale, expected periods in clk cycles
    localparam int CONF[7] = '{'h010, 'h030, 'h092, 'h015, 'h01D, 'h011, 'h019};
    localparam int PRE[7] = '{1, 0, 2, 1, 1, 1, 1};
    localparam int CPUP[7] = '{4, 2, 12, 12, 6, 8, 4};
    localparam int APBP[7] = '{4, 2, 12, 12, 12, 8, 8};
    localparam int CRYP[7] = '{4, 2, 12, 6, 6, 4, 4};
    localparam int SLOWP[7] = '{6, 8, 6, 6, 6, 6, 6};
    localparam int FASTP[7] = '{4, 4, 8, 4, 4, 4, 4};
    // Reset events: levels hit (cpu, digital, rtc, chip, memory), cause, prescale after
    localparam logic [4:0] MASK[5] = '{5'h03, 5'h01, 5'h03, 5'h07, 5'h1F};
    localparam int CAUSE[5] = '{'h03, 'h0C, 'h14, 'h0F, 'h01};
    localparam int PRESC[5] = '{5, 5, 5, 1, 1};
    logic clk = 0;
    logic rst = 1;
    logic [11:0] paddr = '0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    logic [4:0] srcTick = '0; // Crystal, PLL, fast RC, slow RC, LF crystal
    logic brownOutEvent = 0;
    logic fuseCrcError = 0;
    logic radioSleepAck = 0;
    wire logic [11:0] outs; // Ticks then reset levels, counted below
    wire logic radioRun;
    wire logic radioSleepReq;
    wire logic pllInUse;
    int per[5] = '{2, 2, 4, 6, 8};
    int ph[5];
    int cnt[12];
    logic cntClr = 0;
    int fails = 0;
    int checked = 0;
    int cyc = 0;

    csr_top #(.HOLD_CYC(HOLD)) dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystalClockTick(srcTick[0]), .pllClockTick(srcTick[1]), .fastRcClockTick(srcTick[2]),
        .slowRcClockTick(srcTick[3]), .lowFrequencyCrystalClockTick(srcTick[4]),
        .brownOutEvent(brownOutEvent), .fuseCrcError(fuseCrcError), .radioSleepAck(radioSleepAck),
        .cpuClockTick(outs[0]), .apbClockTick(outs[1]), .cryptoEngineClockTick(outs[2]),
        .ledPwmClockTick(outs[3]), .dividedFastRcClockTick(outs[4]), .slowDomainClockTick(outs[5]),
        .fastDomainClockTick(outs[6]), .cpuRst(outs[7]), .digitalRst(outs[8]), .rtcDomainRst(outs[9]),
        .chipRst(outs[10]), .memoryRst(outs[11]), .radioRun(radioRun), .radioSleepReq(radioSleepReq),
        .pllInUse(pllInUse));

    // 200 MHz clock
    initial forever #2.5 clk = ~clk;

    // Source ticks at fixed periods; crystal and PLL share a period of 2, the others are distinct
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            ph[i] <= (ph[i] + 1) % per[i];
            srcTick[i] <= (ph[i] == 0);
        end
    end

    // Count high cycles of every output; an unknown counts as low
    always @(posedge clk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 12; i++) cnt[i] <= cntClr ? 0 : cnt[i] + int'(outs[i] === 1'b1);
        if (cyc == LIMIT) begin
            fails++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer; waits for pready, the global limit cuts a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
        logic [31:0] r;
        logic e;
        apb(0, a, 32'h0000_0000, r, e);
        chk(n, x, r);
    endtask

    task automatic hold(input int n);
        repeat (n + 1) @(posedge clk);
    endtask

    // Start a counting window at the next edge
    task automatic mark;
        cntClr <= 1;
        @(posedge clk);
        cntClr <= 0;
    endtask

    task automatic t_reset_values;
        logic [31:0] r;
        logic e;
        rd(CSR_CLK_CONF_OFS, 32'h0000_0010, "clock config");
        rd(CSR_PRESCALE_OFS, 32'h0000_0001, "prescale");
        rd(CSR_CAUSE_OFS, 32'h0000_0001, "cause after power-on");
        rd(CSR_FAST_DIV_OFS, 32'h0000_0001, "fast divider");
        rd(CSR_RST_CTRL_OFS, 32'h0000_0000, "reset control");
        apb(0, 12'h018, 32'h0000_0000, r, e);
        chk("hole error", 1, e);
        chk("hole data", 0, r);
        $display("reset values done");
    endtask

    // Every source, each PLL ratio, prescale 0, 1, 2 and 1023, and every derived clock, counted over whole periods
    task automatic t_clocks;
        for (int i = 0; i < 7; i++) begin
            wr(CSR_PRESCALE_OFS, PRE[i]);
            wr(CSR_CLK_CONF_OFS, CONF[i]);
            hold(48);
            mark();
            hold(192);
            chk("cpu ticks", 192 / CPUP[i], cnt[0]);
            chk("bus ticks", 192 / APBP[i], cnt[1]);
            chk("crypto ticks", 192 / CRYP[i], cnt[2]);
            chk("slow ticks", 192 / SLOWP[i], cnt[5]);
            chk("fast ticks", 192 / FASTP[i], cnt[6]);
        end
        wr(CSR_CLK_CONF_OFS, 32'h0000_0000);
        hold(48);
        mark();
        hold(192);
        chk("bus ticks off", 0, cnt[1]);
        chk("led ticks", 48, cnt[3]);
        wr(CSR_PRESCALE_OFS, 1023);
        wr(CSR_CLK_CONF_OFS, 32'h0000_0050);
        hold(100);
        mark();
        hold(2048);
        chk("cpu ticks max", 1, cnt[0]);
        chk("divided rc ticks", 2, cnt[4]);
        chk("slow from divided rc", 2, cnt[5]);
        wr(CSR_PRESCALE_OFS, 1);
        wr(CSR_CLK_CONF_OFS, 32'h0000_0010);
        $display("clocks done");
    endtask

    // Leaving the PLL with the radio on waits for its sleep acknowledge
    task automatic t_radio;
        wr(CSR_CLK_CONF_OFS, 32'h0000_0111);
        hold(8);
        chk("radio run", 1, radioRun);
        wr(CSR_CLK_CONF_OFS, 32'h0000_0110);
        hold(8);
        chk("sleep request", 1, radioSleepReq);
        chk("pll still used", 1, pllInUse);
        chk("radio stopped", 0, radioRun);
        rd(CSR_STATUS_OFS, 32'h0000_0031, "status");
        radioSleepAck <= 1;
        @(posedge clk);
        radioSleepAck <= 0;
        hold(8);
        chk("sleep request gone", 0, radioSleepReq);
        chk("pll released", 0, pllInUse);
        $display("radio done");
    endtask

    // Each reset source: levels reached, their length, cause and kept config
    task automatic t_resets;
        wr(CSR_PRESCALE_OFS, 5);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) wr(CSR_RST_CTRL_OFS, 32'h0000_0004);
            mark();
            case (i)
                0: wr(CSR_RST_CTRL_OFS, 32'h0000_0001);
                1: wr(CSR_RST_CTRL_OFS, 32'h0000_0002);
                2: begin
                    fuseCrcError <= 1;
                    @(posedge clk);
                    fuseCrcError <= 0;
                end
                default: begin
                    brownOutEvent <= 1;
                    @(posedge clk);
                    brownOutEvent <= 0;
                end
            endcase
            hold(30);
            for (int j = 0; j < 5; j++) chk("reset length", MASK[i][j] ? HOLD : 0, cnt[7 + j]);
            rd(CSR_CAUSE_OFS, CAUSE[i], "cause");
            rd(CSR_PRESCALE_OFS, PRESC[i], "prescale kept");
        end
        $display("resets done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_reset_values();
        t_clocks();
        t_radio();
        t_resets();
        close_out();
    end
endmodule // csr_top_tb

// ---- hw/csr_reset_hold.sv ----
/*
 * Reset stretcher: a trigger pulse holds the output for HOLD cycles.
 * Assumes the trigger is synchronous to clk.
 */
`timescale 1ns/1ps
module csr_reset_hold #(
    parameter int HOLD = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic trigger,
    output logic holdOut
);
    logic [$clog2(HOLD+1)-1:0] count_reg;
    logic hold_reg;

    // A retrigger restarts the full hold
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
            hold_reg <= 1'b0;
        end else if (trigger) begin
            count_reg <= ($clog2(HOLD+1))'(HOLD - 1);
            hold_reg <= 1'b1;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end else begin
            hold_reg <= 1'b0;
        end
    end

    assign holdOut = hold_reg;
endmodule // csr_reset_hold

// ---- hw/csr_tick_div.sv ----
/*
 * Tick divider: emits one output tick per divMinusOne+1 input ticks.
 * Assumes input ticks are one-cycle pulses synchronous to clk.
 */
`timescale 1ns/1ps
module csr_tick_div #(
    parameter int WIDTH = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inTick,
    input wire logic [WIDTH-1:0] divMinusOne,
    output logic outTick
);
    logic [WIDTH-1:0] count_reg;
    logic outTick_reg;
    // Wrap when the count reaches the limit; a limit lowered mid-count
    // also wraps, so a new ratio takes hold within one period
    wire wrap = inTick && (count_reg >= divMinusOne);

    // Count source ticks, pulse on wrap
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
            outTick_reg <= 1'b0;
        end else begin
            outTick_reg <= wrap;
            if (wrap) begin
                count_reg <= '0;
            end else if (inTick) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    assign outTick = outTick_reg;
endmodule // csr_tick_div

// ---- hw/csr_top.sv ----
/*
 * Clock select and reset cause controller with APB registers.
 * Source clocks arrive as one-cycle ticks synchronous to clk; derived
 * clocks leave as ticks. Reset outputs are active high levels.
 */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module csr_top #(
    parameter int HOLD_CYC = csr_pkg::CSR_RST_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crystalClockTick,
    input wire logic pllClockTick,
    input wire logic fastRcClockTick,
    input wire logic slowRcClockTick,
    input wire logic lowFrequencyCrystalClockTick,
    input wire logic brownOutEvent,
    input wire logic fuseCrcError,
    input wire logic radioSleepAck,
    output logic cpuClockTick,
    output logic apbClockTick,
    output logic cryptoEngineClockTick,
    output logic ledPwmClockTick,
    output logic dividedFastRcClockTick,
    output logic slowDomainClockTick,
    output logic fastDomainClockTick,
    output logic cpuRst,
    output logic digitalRst,
    output logic rtcDomainRst,
    output logic chipRst,
    output logic memoryRst,
    output logic radioRun,
    output logic radioSleepReq,
    output logic pllInUse
);
    import csr_pkg::*;

    // Software visible state
    logic [8:0] clkConf_reg;
    logic [9:0] prescale_reg;
    logic [9:0] fastDiv_reg;
    logic bodChip_reg;
    logic swSysReq_reg;
    logic swCpuReq_reg;
    logic [7:0] cause_reg;
    logic [31:0] prdata_reg;
    // Source actually feeding the core clock
    logic [1:0] activeSrc_reg;
    logic [1:0] activeSrc_next;
    csr_radio_st_t state_reg;
    csr_radio_st_t state_next;
    // Registered clock ticks
    logic cpuTick_reg;
    logic apbTick_reg;
    logic cryptoTick_reg;
    logic ledTick_reg;
    logic slowTick_reg;
    // Divider outputs
    logic cpuDivTick;
    logic apbPllTick;
    logic cryptoPllTick;
    logic divRcTick;
    logic fastDivTick;
    // Reset stretcher outputs
    logic chipHold;
    logic sysHold;
    logic coreHold;
    logic cpuHold;

    // APB phase and address decode
    wire setupPhase = psel && !penable;
    wire accessPhase = psel && penable;
    wire hitConf = (paddr == CSR_CLK_CONF_OFS);
    wire hitPre = (paddr == CSR_PRESCALE_OFS);
    wire hitRst = (paddr == CSR_RST_CTRL_OFS);
    wire hitCause = (paddr == CSR_CAUSE_OFS);
    wire hitStat = (paddr == CSR_STATUS_OFS);
    wire hitFast = (paddr == CSR_FAST_DIV_OFS);
    wire addrHit = hitConf | hitPre | hitRst | hitCause | hitStat | hitFast;
    wire wrEn = accessPhase && pwrite && addrHit;
    // Byte lanes expanded to a bit mask
    wire [31:0] laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] wrBits = pwdata & laneMask;

    // Merge enabled lanes of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~laneMask) | wrBits;
    endfunction

    wire [31:0] confMerged = merge({23'h0000_00, clkConf_reg});
    wire [31:0] preMerged = merge({22'h00_0000, prescale_reg});
    wire [31:0] fastMerged = merge({22'h00_0000, fastDiv_reg});

    // Zero wait states; unmapped offsets answer with an error
    assign pready = accessPhase;
    assign pslverr = accessPhase && !addrHit;

    // Reset levels nest: each wider one implies the narrower ones
    assign chipRst = rst | chipHold;
    assign rtcDomainRst = chipRst | sysHold;
    assign digitalRst = rtcDomainRst | coreHold;
    assign cpuRst = digitalRst | cpuHold;
    // Memory contents survive all but the chip-level reset
    assign memoryRst = chipRst;

    // Brown-out level follows the software choice
    wire chipEvent = brownOutEvent && bodChip_reg;
    wire sysEvent = brownOutEvent && !bodChip_reg;
    wire coreEvent = swSysReq_reg || fuseCrcError;
    wire cpuEvent = swCpuReq_reg;

    // Configuration lives in the always-on domain
    wire cfgRst = rtcDomainRst;

    // One stretcher per reset level
    csr_reset_hold #(.HOLD(HOLD_CYC)) u_chipHold (
        .clk(clk),
        .rst(rst),
        .trigger(chipEvent),
        .holdOut(chipHold)
    );
    csr_reset_hold #(.HOLD(HOLD_CYC)) u_sysHold (
        .clk(clk),
        .rst(rst),
        .trigger(sysEvent),
        .holdOut(sysHold)
    );
    csr_reset_hold #(.HOLD(HOLD_CYC)) u_coreHold (
        .clk(clk),
        .rst(rst),
        .trigger(coreEvent),
        .holdOut(coreHold)
    );
    csr_reset_hold #(.HOLD(HOLD_CYC)) u_cpuHold (
        .clk(clk),
        .rst(rst),
        .trigger(cpuEvent),
        .holdOut(cpuHold)
    );

    // Configuration registers; cleared by system or chip reset
    always_ff @(posedge clk) begin
        if (cfgRst) begin
            clkConf_reg <= CSR_CLK_CONF_RST;
            prescale_reg <= CSR_PRESCALE_RST;
            fastDiv_reg <= CSR_FAST_DIV_RST;
            bodChip_reg <= 1'b0;
        end else if (wrEn) begin
            if (hitConf) begin
                clkConf_reg <= confMerged[8:0];
            end
            if (hitPre) begin
                prescale_reg <= preMerged[9:0];
            end
            if (hitFast) begin
                fastDiv_reg <= fastMerged[9:0];
            end
            if (hitRst && pstrb[0]) begin
                bodChip_reg <= pwdata[CSR_BOD_CHIP_BIT];
            end
        end
    end

    // Request bits are one-cycle pulses and read back as zero
    wire reqWrite = wrEn && hitRst && pstrb[0];
    always_ff @(posedge clk) begin
        if (cfgRst) begin
            swSysReq_reg <= 1'b0;
            swCpuReq_reg <= 1'b0;
        end else begin
            swSysReq_reg <= reqWrite && pwdata[CSR_SW_SYS_BIT];
            swCpuReq_reg <= reqWrite && pwdata[CSR_SW_CPU_BIT];
        end
    end

    // Cause register is only cleared by power-on; the widest event wins,
    // and a narrower event under a wider held reset is not recorded
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_reg <= CSR_CAUSE_CHIP;
        end else if (chipEvent) begin
            cause_reg <= CSR_CAUSE_CHIP;
        end else if (sysEvent && !chipHold) begin
            cause_reg <= CSR_CAUSE_BROWNOUT;
        end else if (fuseCrcError && !rtcDomainRst) begin
            cause_reg <= CSR_CAUSE_FUSE;
        end else if (swSysReq_reg && !rtcDomainRst) begin
            cause_reg <= CSR_CAUSE_SW_SYS;
        end else if (cpuEvent && !digitalRst) begin
            cause_reg <= CSR_CAUSE_SW_CPU;
        end
    end

    // Read mux; reserved bits read as zero
    wire [31:0] statusWord = {26'h000_0000, pllInUse, radioSleepReq, radioRun, bodChip_reg, activeSrc_reg};
    wire [31:0] readData = hitConf ? {23'h0000_00, clkConf_reg} :
        hitPre ? {22'h00_0000, prescale_reg} :
        hitRst ? {29'h0000_0000, bodChip_reg, 2'h0} :
        hitCause ? {24'h00_0000, cause_reg} :
        hitStat ? statusWord :
        hitFast ? {22'h00_0000, fastDiv_reg} : 32'h0000_0000;

    // Read data is captured in the setup cycle and stands through access
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setupPhase) begin
            prdata_reg <= readData;
        end
    end
    assign prdata = prdata_reg;

    // Configuration field views
    wire [1:0] reqSrc = clkConf_reg[CSR_SRC_LSB +: 2];
    wire pll480 = clkConf_reg[CSR_PLL_FREQ_BIT];
    wire period160 = clkConf_reg[CSR_PERIOD_BIT];
    wire apbEnable = clkConf_reg[CSR_APB_EN_BIT];
    wire [1:0] slowSel = clkConf_reg[CSR_SLOW_LSB +: 2];
    wire fastSelRc = clkConf_reg[CSR_FAST_SEL_BIT];
    wire radioEnable = clkConf_reg[CSR_RADIO_EN_BIT];
    wire onPll = (activeSrc_reg == CSR_SRC_PLL);

    // Radio may only run on the PLL source
    assign radioRun = radioEnable && onPll && (state_reg == CSR_ST_RUN);
    assign radioSleepReq = (state_reg == CSR_ST_WAIT_SLEEP);
    assign pllInUse = onPll;

    // Source switch: leaving the PLL while the radio runs first asks the
    // radio to sleep, and the switch waits for its acknowledge
    always_comb begin
        state_next = state_reg;
        activeSrc_next = activeSrc_reg;
        case (state_reg)
            CSR_ST_RUN: begin
                if (reqSrc != activeSrc_reg) begin
                    if (radioRun && reqSrc != CSR_SRC_PLL) begin
                        state_next = CSR_ST_WAIT_SLEEP;
                    end else begin
                        activeSrc_next = reqSrc;
                    end
                end
            end
            CSR_ST_WAIT_SLEEP: begin
                if (reqSrc == CSR_SRC_PLL) begin
                    state_next = CSR_ST_RUN;
                end else if (radioSleepAck) begin
                    activeSrc_next = reqSrc;
                    state_next = CSR_ST_RUN;
                end
            end
            default: begin
                state_next = CSR_ST_RUN;
            end
        endcase
    end

    // Source state follows the always-on reset
    always_ff @(posedge clk) begin
        if (cfgRst) begin
            state_reg <= CSR_ST_RUN;
            activeSrc_reg <= CSR_SRC_XTAL;
        end else begin
            state_reg <= state_next;
            activeSrc_reg <= activeSrc_next;
        end
    end

    // Core clock source mux; the unused code falls back to crystal
    wire cpuSrcTick = (activeSrc_reg == CSR_SRC_PLL) ? pllClockTick :
        (activeSrc_reg == CSR_SRC_FAST_RC) ? fastRcClockTick : crystalClockTick;

    // PLL ratios give 80 or 160 MHz for either PLL frequency
    wire [9:0] pllCpuDiv = period160 ? (pll480 ? CSR_PLL480_DIV160 : CSR_PLL320_DIV160) :
        (pll480 ? CSR_PLL480_DIV80 : CSR_PLL320_DIV80);
    wire [9:0] pllApbDiv = pll480 ? CSR_PLL480_DIV80 : CSR_PLL320_DIV80;
    wire [9:0] pllCryptoDiv = pll480 ? CSR_PLL480_DIV160 : CSR_PLL320_DIV160;
    wire [9:0] cpuDivM1 = onPll ? 10'(pllCpuDiv - 10'h001) : prescale_reg;

    // Core clock divider
    csr_tick_div #(.WIDTH(10)) u_cpuDiv (
        .clk(clk),
        .rst(rst),
        .inTick(cpuSrcTick),
        .divMinusOne(cpuDivM1),
        .outTick(cpuDivTick)
    );
    // Bus clock from the PLL
    csr_tick_div #(.WIDTH(10)) u_apbDiv (
        .clk(clk),
        .rst(rst),
        .inTick(pllClockTick),
        .divMinusOne(10'(pllApbDiv - 10'h001)),
        .outTick(apbPllTick)
    );
    // Crypto clock from the PLL
    csr_tick_div #(.WIDTH(10)) u_cryptoDiv (
        .clk(clk),
        .rst(rst),
        .inTick(pllClockTick),
        .divMinusOne(10'(pllCryptoDiv - 10'h001)),
        .outTick(cryptoPllTick)
    );
    // Fixed divide of the fast RC clock
    csr_tick_div #(.WIDTH(10)) u_rcDiv (
        .clk(clk),
        .rst(rst),
        .inTick(fastRcClockTick),
        .divMinusOne(10'(CSR_FAST_RC_DIV - 10'h001)),
        .outTick(divRcTick)
    );
    // Fast domain divider on crystal or fast RC
    csr_tick_div #(.WIDTH(10)) u_fastDiv (
        .clk(clk),
        .rst(rst),
        .inTick(fastSelRc ? fastRcClockTick : crystalClockTick),
        .divMinusOne(fastDiv_reg),
        .outTick(fastDivTick)
    );

    // Derived clocks; the bus clock can be switched off by software
    wire apbRaw = onPll ? apbPllTick : cpuDivTick;
    wire cryptoRaw = onPll ? cryptoPllTick : cpuDivTick;
    wire ledRaw = apbEnable ? apbRaw : fastRcClockTick;
    wire slowRaw = (slowSel == CSR_SLOW_LF_XTAL) ? lowFrequencyCrystalClockTick :
        (slowSel == CSR_SLOW_DIV_RC) ? divRcTick : slowRcClockTick;

    // The cpu, bus, crypto, LED and slow ticks pass one register stage; divided RC and fast domain ticks leave their dividers directly
    always_ff @(posedge clk) begin
        if (rst) begin
            cpuTick_reg <= 1'b0;
            apbTick_reg <= 1'b0;
            cryptoTick_reg <= 1'b0;
            ledTick_reg <= 1'b0;
            slowTick_reg <= 1'b0;
        end else begin
            cpuTick_reg <= cpuDivTick;
            apbTick_reg <= apbEnable && apbRaw;
            cryptoTick_reg <= cryptoRaw;
            ledTick_reg <= ledRaw;
            slowTick_reg <= slowRaw;
        end
    end

    assign cpuClockTick = cpuTick_reg;
    assign apbClockTick = apbTick_reg;
    assign cryptoEngineClockTick = cryptoTick_reg;
    assign ledPwmClockTick = ledTick_reg;
    assign slowDomainClockTick = slowTick_reg;
    assign dividedFastRcClockTick = divRcTick;
    assign fastDomainClockTick = fastDivTick;
endmodule // csr_top
